/* verilog/etcu_pkg.sv */
// Constants and types shared by the eight-bit timer compare unit
package etcu_pkg;

	// ---------------------------------------------------------------
	// Register offsets
	// ---------------------------------------------------------------
	localparam logic [2:0] ETCU_OFS_CONTROL = 3'h0;
	localparam logic [2:0] ETCU_OFS_COUNT   = 3'h1;
	localparam logic [2:0] ETCU_OFS_COMPARE = 3'h2;
	localparam logic [2:0] ETCU_OFS_ASYNC   = 3'h3;
	localparam logic [2:0] ETCU_OFS_FLAG    = 3'h4;
	localparam logic [2:0] ETCU_OFS_MASK    = 3'h5;

	// ---------------------------------------------------------------
	// Field positions
	// ---------------------------------------------------------------
	localparam int ETCU_CTL_FORCE     = 7;
	localparam int ETCU_CTL_WAVE_LOW  = 6;
	localparam int ETCU_CTL_BEH_HI    = 5;
	localparam int ETCU_CTL_BEH_LO    = 4;
	localparam int ETCU_CTL_WAVE_HIGH = 3;
	localparam int ETCU_CTL_CS_HI     = 2;
	localparam int ETCU_ASYNC_SEL     = 3;
	localparam int ETCU_FLAG_CMP      = 7;
	localparam int ETCU_FLAG_OVF      = 6;

	// ---------------------------------------------------------------
	// Values and reset values
	// ---------------------------------------------------------------
	localparam logic [7:0] ETCU_BOTTOM    = 8'h00;
	localparam logic [7:0] ETCU_MAX       = 8'hff;
	localparam logic [7:0] ETCU_RST_BYTE  = 8'h00;
	localparam logic [2:0] ETCU_CS_STOP   = 3'h0;

	// Prescaler tap masks for clock select 1..7 (/1 /8 /32 /64 /128
	// /256 /1024)
	localparam logic [9:0] ETCU_DIV1    = 10'h000;
	localparam logic [9:0] ETCU_DIV8    = 10'h007;
	localparam logic [9:0] ETCU_DIV32   = 10'h01f;
	localparam logic [9:0] ETCU_DIV64   = 10'h03f;
	localparam logic [9:0] ETCU_DIV128  = 10'h07f;
	localparam logic [9:0] ETCU_DIV256  = 10'h0ff;
	localparam logic [9:0] ETCU_DIV1024 = 10'h3ff;

	// ---------------------------------------------------------------
	// Modes
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		ETCU_WM_NORMAL = 2'h0,
		ETCU_WM_PHASE  = 2'h1,
		ETCU_WM_CTC    = 2'h2,
		ETCU_WM_FAST   = 2'h3
	} etcu_wave_type;

	typedef enum logic [1:0] {
		ETCU_OB_OFF    = 2'h0,
		ETCU_OB_TOGGLE = 2'h1,
		ETCU_OB_CLEAR  = 2'h2,
		ETCU_OB_SET    = 2'h3
	} etcu_beh_type;

endpackage

/* verilog/etcu_core_if.sv */
// Signals between the counter, the tick source and the waveform unit
`timescale 1ns/1ps
interface etcu_core_if;
	import etcu_pkg::*;

	logic          tick;      // One-cycle timer tick
	logic [2:0]    cs;        // Clock source select
	logic          async_sel; // Oscillator pin selected
	logic [7:0]    count;     // Counter value
	logic [7:0]    compare;   // Active compare value
	logic          dir_up;    // Count direction in phase mode
	etcu_wave_type mode;      // Waveform mode
	etcu_beh_type  beh;       // Output behaviour
	logic          blocked;   // Match suppressed this tick
	logic          force_cmp; // Forced match pulse
	logic          oc;        // Compare output state

	modport tick_side (input cs, async_sel, output tick);
	modport cnt_side  (input tick, oc,
		output cs, async_sel, count, compare, dir_up, mode, beh,
		blocked, force_cmp);
	modport wave_side (input tick, count, compare, dir_up, mode, beh,
		blocked, force_cmp, output oc);
endinterface

/* verilog/etcu_tick_gen.sv */
// Clock select and prescaler producing the timer tick
`timescale 1ns/1ps
module etcu_tick_gen
	import etcu_pkg::*;
(
	input  wire logic      i_clk,       // System clock
	input  wire logic      i_arst_n,    // Async reset, active low
	input  wire logic      i_osc_pin,   // Oscillator pin, raw
	etcu_core_if.tick_side core         // Tick to counter
);
	typedef struct packed {
		logic [2:0] sync;
		logic [9:0] pre;
		logic       tick;
	} etcu_tick_type;

	etcu_tick_type st_reg;
	etcu_tick_type st_next;
	logic          src_en;
	logic [9:0]    mask;

	always_comb begin
		st_next = st_reg;
		st_next.sync = {st_reg.sync[1:0], i_osc_pin};
		// Only stages two and three feed the edge detector
		src_en = core.async_sel ? (st_reg.sync[1] & ~st_reg.sync[2])
			: 1'b1;
		case (core.cs)
			3'h1:    mask = ETCU_DIV1;
			3'h2:    mask = ETCU_DIV8;
			3'h3:    mask = ETCU_DIV32;
			3'h4:    mask = ETCU_DIV64;
			3'h5:    mask = ETCU_DIV128;
			3'h6:    mask = ETCU_DIV256;
			3'h7:    mask = ETCU_DIV1024;
			default: mask = ETCU_DIV1;
		endcase
		st_next.tick = 1'b0;
		if (core.cs == ETCU_CS_STOP) begin
			st_next.pre = '0;
		end else if (src_en) begin
			st_next.pre = st_reg.pre + 10'h001;
			st_next.tick = ((st_reg.pre & mask) == mask);
		end
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign core.tick = st_reg.tick;
endmodule

/* verilog/etcu_wave_gen.sv */
// Waveform generator forming the compare output
`timescale 1ns/1ps
module etcu_wave_gen
	import etcu_pkg::*;
(
	input  wire logic      i_clk,    // System clock
	input  wire logic      i_arst_n, // Async reset, active low
	etcu_core_if.wave_side core      // Counter state in, output out
);
	typedef struct packed {
		logic oc;
	} etcu_wave_st_type;

	etcu_wave_st_type st_reg;
	etcu_wave_st_type st_next;
	logic             hit;
	logic             bottom;
	logic             up;

	always_comb begin
		st_next = st_reg;
		hit = core.tick && !core.blocked
			&& (core.count == core.compare);
		// Bottom is the tick that wraps MAX back to zero
		bottom = core.tick && (core.count == ETCU_MAX);
		// At the extremes the slope is known from the value itself
		up = (core.count == ETCU_BOTTOM)
			|| (core.dir_up && core.count != ETCU_MAX);
		case (core.mode)
			ETCU_WM_NORMAL, ETCU_WM_CTC: begin
				if (hit || core.force_cmp) begin
					case (core.beh)
						ETCU_OB_TOGGLE: st_next.oc = ~st_reg.oc;
						ETCU_OB_CLEAR:  st_next.oc = 1'b0;
						ETCU_OB_SET:    st_next.oc = 1'b1;
						default:        st_next.oc = st_reg.oc;
					endcase
				end
			end
			ETCU_WM_FAST: begin
				// Bottom wins so a compare of MAX gives a steady level
				if (core.beh[1] && bottom) begin
					st_next.oc = (core.beh == ETCU_OB_CLEAR);
				end else if (core.beh[1] && hit) begin
					st_next.oc = (core.beh == ETCU_OB_SET);
				end
			end
			ETCU_WM_PHASE: begin
				if (core.beh[1] && hit) begin
					st_next.oc = (core.beh == ETCU_OB_SET) ? up : ~up;
				end
			end
			default: st_next = st_reg;
		endcase
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign core.oc = st_reg.oc;
endmodule

/* verilog/etcu_timer.sv */
// Eight-bit timer with one compare unit, top level
`timescale 1ns/1ps
module etcu_timer
	import etcu_pkg::*;
(
	input  wire logic       i_clk,          // System clock, 10 MHz
	input  wire logic       i_arst_n,       // Async reset, active low
	input  wire logic [2:0] i_addr,         // Register offset
	input  wire logic [7:0] i_wdata,        // Write data
	input  wire logic       i_wr,           // Write strobe
	input  wire logic       i_rd,           // Read strobe
	output logic      [7:0] o_rdata,        // Read data, cycle after
	input  wire logic       i_osc_pin_one,  // Oscillator pin, async
	input  wire logic       i_compare_ack,  // Compare irq serviced
	input  wire logic       i_overflow_ack, // Overflow irq serviced
	output logic            o_compare_irq,  // Compare interrupt req
	output logic            o_overflow_irq, // Overflow interrupt req
	output logic            o_compare_output, // Compare output pin
	output logic            o_compare_oe_n  // Pin enable, low drives
);
	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [2:0]    cs;
		etcu_wave_type mode;
		etcu_beh_type  beh;
		logic          async_sel;
		logic [7:0]    count;
		logic [7:0]    compare;
		logic [7:0]    cmp_buf;
		logic          dir_up;
		logic          blocked;
		logic          force_cmp;
		logic          cmp_flag;
		logic          ovf_flag;
		logic          cmp_en;
		logic          ovf_en;
		logic          cmp_irq;
		logic          ovf_irq;
		logic          oe_n;
		logic [7:0]    rdata;
	} etcu_state_type;

	etcu_state_type st_reg;
	etcu_state_type st_next;
	etcu_core_if    core ();

	logic       wr_ctl;
	logic       wr_cnt;
	logic       wr_cmp;
	logic       wr_flag;
	logic       wr_mask;
	logic       is_pwm;
	logic       at_bottom;
	logic       at_max;
	logic       match;
	logic       cmp_set;
	logic       ovf_set;
	logic       reload;
	logic [7:0] cnt_step;
	logic       dir_step;

	// ---------------------------------------------------------------
	// Submodules
	// ---------------------------------------------------------------
	etcu_tick_gen u_tick (
		.i_clk     (i_clk),
		.i_arst_n  (i_arst_n),
		.i_osc_pin (i_osc_pin_one),
		.core      (core.tick_side)
	);

	etcu_wave_gen u_wave (
		.i_clk    (i_clk),
		.i_arst_n (i_arst_n),
		.core     (core.wave_side)
	);

	assign core.cs        = st_reg.cs;
	assign core.async_sel = st_reg.async_sel;
	assign core.count     = st_reg.count;
	assign core.compare   = st_reg.compare;
	assign core.dir_up    = st_reg.dir_up;
	assign core.mode      = st_reg.mode;
	assign core.beh       = st_reg.beh;
	assign core.blocked   = st_reg.blocked;
	assign core.force_cmp = st_reg.force_cmp;

	// ---------------------------------------------------------------
	// Counter, compare and flags
	// ---------------------------------------------------------------
	always_comb begin
		st_next = st_reg;
		wr_ctl  = i_wr && (i_addr == ETCU_OFS_CONTROL);
		wr_cnt  = i_wr && (i_addr == ETCU_OFS_COUNT);
		wr_cmp  = i_wr && (i_addr == ETCU_OFS_COMPARE);
		wr_flag = i_wr && (i_addr == ETCU_OFS_FLAG);
		wr_mask = i_wr && (i_addr == ETCU_OFS_MASK);
		is_pwm  = (st_reg.mode == ETCU_WM_PHASE)
			|| (st_reg.mode == ETCU_WM_FAST);
		at_bottom = (st_reg.count == ETCU_BOTTOM);
		at_max    = (st_reg.count == ETCU_MAX);
		match     = (st_reg.count == st_reg.compare);

		// Next count for one tick in the selected sequence
		cnt_step = st_reg.count + 8'h01;
		dir_step = st_reg.dir_up;
		ovf_set  = 1'b0;
		reload   = 1'b0;
		case (st_reg.mode)
			ETCU_WM_NORMAL: begin
				ovf_set = at_max;
			end
			ETCU_WM_CTC: begin
				if (match) begin
					cnt_step = ETCU_BOTTOM;
				end
				ovf_set = at_max && !match;
			end
			ETCU_WM_FAST: begin
				ovf_set = at_max;
				reload  = at_max;
			end
			ETCU_WM_PHASE: begin
				if (st_reg.dir_up) begin
					if (at_max) begin
						cnt_step = ETCU_MAX - 8'h01;
						dir_step = 1'b0;
					end
				end else if (at_bottom) begin
					dir_step = 1'b1;
				end else begin
					cnt_step = st_reg.count - 8'h01;
				end
				ovf_set = at_bottom;
				reload  = at_max;
			end
			default: cnt_step = st_reg.count;
		endcase

		if (wr_cnt) begin
			st_next.count = i_wdata;
		end else if (core.tick) begin
			st_next.count  = cnt_step;
			st_next.dir_up = dir_step;
		end

		// A count write hides the match from the next tick only
		if (wr_cnt) begin
			st_next.blocked = 1'b1;
		end else if (core.tick) begin
			st_next.blocked = 1'b0;
		end
		cmp_set = core.tick && match && !st_reg.blocked;

		if (wr_cmp) begin
			st_next.cmp_buf = i_wdata;
			if (!is_pwm) begin
				st_next.compare = i_wdata;
			end
		end
		if (is_pwm && core.tick && reload) begin
			st_next.compare = st_next.cmp_buf;
		end

		st_next.force_cmp = 1'b0;
		if (wr_ctl) begin
			st_next.cs   = i_wdata[ETCU_CTL_CS_HI:0];
			st_next.mode = etcu_wave_type'({i_wdata[ETCU_CTL_WAVE_HIGH],
				i_wdata[ETCU_CTL_WAVE_LOW]});
			st_next.beh  = etcu_beh_type'(
				i_wdata[ETCU_CTL_BEH_HI:ETCU_CTL_BEH_LO]);
			// The mode being written decides; both PWM codes set the low bit
			st_next.force_cmp = i_wdata[ETCU_CTL_FORCE]
				&& !i_wdata[ETCU_CTL_WAVE_LOW];
		end
		if (i_wr && (i_addr == ETCU_OFS_ASYNC)) begin
			st_next.async_sel = i_wdata[ETCU_ASYNC_SEL];
		end
		if (wr_mask) begin
			st_next.cmp_en = i_wdata[ETCU_FLAG_CMP];
			st_next.ovf_en = i_wdata[ETCU_FLAG_OVF];
		end

		// Clears first so that a set in the same cycle wins
		if ((wr_flag && i_wdata[ETCU_FLAG_CMP]) || i_compare_ack) begin
			st_next.cmp_flag = 1'b0;
		end
		if ((wr_flag && i_wdata[ETCU_FLAG_OVF]) || i_overflow_ack) begin
			st_next.ovf_flag = 1'b0;
		end
		if (cmp_set) begin
			st_next.cmp_flag = 1'b1;
		end
		if (core.tick && ovf_set && !wr_cnt) begin
			st_next.ovf_flag = 1'b1;
		end
		st_next.cmp_irq = st_next.cmp_flag && st_next.cmp_en;
		st_next.ovf_irq = st_next.ovf_flag && st_next.ovf_en;
		st_next.oe_n    = (st_next.beh == ETCU_OB_OFF);

		// ---------------------------------------------------------
		// Read data, valid only in the cycle after the strobe
		// ---------------------------------------------------------
		st_next.rdata = ETCU_RST_BYTE;
		if (i_rd) begin
			case (i_addr)
				ETCU_OFS_CONTROL: st_next.rdata = {1'b0,
					st_reg.mode[0], st_reg.beh, st_reg.mode[1],
					st_reg.cs};
				ETCU_OFS_COUNT:   st_next.rdata = st_reg.count;
				// Software sees the value it last wrote
				ETCU_OFS_COMPARE: st_next.rdata = st_reg.cmp_buf;
				ETCU_OFS_ASYNC:   st_next.rdata[ETCU_ASYNC_SEL] =
					st_reg.async_sel;
				ETCU_OFS_FLAG: begin
					st_next.rdata[ETCU_FLAG_CMP] = st_reg.cmp_flag;
					st_next.rdata[ETCU_FLAG_OVF] = st_reg.ovf_flag;
				end
				ETCU_OFS_MASK: begin
					st_next.rdata[ETCU_FLAG_CMP] = st_reg.cmp_en;
					st_next.rdata[ETCU_FLAG_OVF] = st_reg.ovf_en;
				end
				default: st_next.rdata = ETCU_RST_BYTE;
			endcase
		end
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			st_reg        <= '0;
			st_reg.dir_up <= 1'b1;
			st_reg.oe_n   <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
	end

	assign o_rdata          = st_reg.rdata;
	assign o_compare_irq    = st_reg.cmp_irq;
	assign o_overflow_irq   = st_reg.ovf_irq;
	assign o_compare_output = core.oc;
	assign o_compare_oe_n   = st_reg.oe_n;
endmodule

/* sim/etcu_timer_sva.sv */
// Port-level checks of the timer register bus and interrupt gating
`timescale 1ns/1ps
module etcu_timer_sva
	import etcu_pkg::*;
(
	input  wire logic       i_clk,            // Clock
	input  wire logic       i_arst_n,         // Reset, active low
	input  wire logic [2:0] i_addr,           // Offset
	input  wire logic [7:0] i_wdata,          // Write data
	input  wire logic       i_wr,             // Write strobe
	input  wire logic       i_rd,             // Read strobe
	input  wire logic [7:0] o_rdata,          // Read data
	input  wire logic       i_osc_pin_one,    // Oscillator pin
	input  wire logic       i_compare_ack,    // Compare serviced
	input  wire logic       i_overflow_ack,   // Overflow serviced
	input  wire logic       o_compare_irq,    // Compare request
	input  wire logic       o_overflow_irq,   // Overflow request
	input  wire logic       o_compare_output, // Output pin
	input  wire logic       o_compare_oe_n    // Pin enable
);
	logic en_cmp_reg;
	logic en_ovf_reg;

	// Mirror of the mask bits, seen only through bus writes
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			en_cmp_reg <= 1'b0;
			en_ovf_reg <= 1'b0;
		end else if (i_wr && i_addr == ETCU_OFS_MASK) begin
			en_cmp_reg <= i_wdata[ETCU_FLAG_CMP];
			en_ovf_reg <= i_wdata[ETCU_FLAG_OVF];
		end
	end

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_arst_n);

	property p_back(logic [2:0] a, logic [7:0] m);
		logic [7:0] d;
		(i_wr && i_addr == a, d = i_wdata) ##1 (i_rd && i_addr == a)
			|=> (o_rdata & m) == (d & m);
	endproperty

	property p_oe;
		logic b;
		(i_wr && i_addr == ETCU_OFS_CONTROL, b = (i_wdata[5:4] == 2'h0))
			|-> ##2 o_compare_oe_n == b;
	endproperty

	AST_RDATA_IDLE: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
		else $error("read data not zero outside a read answer");
	AST_UNMAPPED: assert property ((i_rd && i_addr > ETCU_OFS_MASK) |=> o_rdata == 8'h00)
		else $error("unmapped offset read not zero");
	AST_FORCE_RD0: assert property ((i_rd && i_addr == ETCU_OFS_CONTROL) |=> !o_rdata[ETCU_CTL_FORCE])
		else $error("force strobe bit read back as one");
	AST_CMP_RDBACK: assert property (p_back(ETCU_OFS_COMPARE, 8'hff))
		else $error("compare value read back wrong");
	AST_MASK_RDBACK: assert property (p_back(ETCU_OFS_MASK, 8'hc0))
		else $error("mask bits read back wrong");
	AST_ASYNC_RDBACK: assert property (p_back(ETCU_OFS_ASYNC, 8'h08))
		else $error("async select read back wrong");
	AST_CMP_GATE: assert property ($rose(o_compare_irq) |-> en_cmp_reg)
		else $error("compare request rose while masked");
	AST_OVF_GATE: assert property ($rose(o_overflow_irq) |-> en_ovf_reg)
		else $error("overflow request rose while masked");
	AST_MASK_OFF: assert property ((i_wr && i_addr == ETCU_OFS_MASK && !i_wdata[7]) |-> ##2 !o_compare_irq)
		else $error("compare request stayed after mask cleared");
	AST_OE: assert property (p_oe)
		else $error("pin enable does not follow output behaviour");

	cover property ($rose(o_compare_irq));
	cover property ($rose(o_overflow_irq));
	cover property (!o_compare_oe_n && $changed(o_compare_output));
endmodule

/* sim/tb_top.sv */
// Self-checking bench for the eight-bit timer compare unit
`timescale 1ns/1ps
module tb_top
	import etcu_pkg::*;
;
	logic       i_clk          = 1'b0;
	logic       i_arst_n       = 1'b0;
	logic [2:0] i_addr         = 3'h0;
	logic [7:0] i_wdata        = 8'h00;
	logic       i_wr           = 1'b0;
	logic       i_rd           = 1'b0;
	logic       i_osc_pin_one  = 1'b0;
	logic       i_compare_ack  = 1'b0;
	logic       i_overflow_ack = 1'b0;
	logic [7:0] o_rdata;
	logic       o_compare_irq;
	logic       o_overflow_irq;
	logic       o_compare_output;
	logic       o_compare_oe_n;
	int         failures = 0;
	int         n_checks = 0;
	int         rng      = 81;
	int         m_reg [8];
	logic [7:0] got;
	logic [7:0] v;
	int         k;
	int         t;

	always #50 i_clk = ~i_clk;

	etcu_timer DUT (
		.i_clk(i_clk), .i_arst_n(i_arst_n), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.i_osc_pin_one(i_osc_pin_one), .i_compare_ack(i_compare_ack),
		.i_overflow_ack(i_overflow_ack), .o_compare_irq(o_compare_irq),
		.o_overflow_irq(o_overflow_irq),
		.o_compare_output(o_compare_output),
		.o_compare_oe_n(o_compare_oe_n)
	);

	// ---------------------------------------------------------------
	// Bus tasks and model
	// ---------------------------------------------------------------
	task automatic tally_and_finish();
		if (failures == 0 && n_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	function automatic logic [7:0] rnd();
		rng = rng ^ (rng << 13);
		rng = rng ^ (rng >> 17);
		rng = rng ^ (rng << 5);
		return rng[7:0];
	endfunction

	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		n_checks++;
		if (g !== e) begin
			failures++;
			$display("[FAIL] %0t got %h expected %h", $time, g, e);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask

	// Flags clear on written ones; the force strobe never reads back
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		i_addr  <= a;
		i_wdata <= d;
		i_wr    <= 1'b1;
		@(posedge i_clk);
		i_wr <= 1'b0;
		if (a == ETCU_OFS_FLAG) begin
			m_reg[a] = m_reg[a] & ~int'(d);
		end else if (a < 3'h6) begin
			m_reg[a] = (a == ETCU_OFS_CONTROL) ? d & 8'h7f : d;
		end
		#1;
	endtask

	task automatic rd(input logic [2:0] a);
		i_addr <= a;
		i_rd   <= 1'b1;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1;
		got = o_rdata;
	endtask

	task automatic rdm(input logic [2:0] a);
		rd(a);
		chk(got, 8'(m_reg[a]));
	endtask

	task automatic ack(input bit ovf);
		i_overflow_ack <= ovf;
		i_compare_ack  <= !ovf;
		@(posedge i_clk);
		i_overflow_ack <= 1'b0;
		i_compare_ack  <= 1'b0;
		#1;
	endtask

	task automatic wait_irq(input bit ovf, input int lim);
		t = 0;
		while ((ovf ? o_overflow_irq : o_compare_irq) !== 1'b1) begin
			if (t == lim) begin
				failures++;
				$display("[FAIL] %0t interrupt wait timed out", $time);
				tally_and_finish();
			end else begin
				t++;
				cyc(1);
			end
		end
	endtask

	task automatic osc(input int n);
		repeat (n) begin
			i_osc_pin_one <= 1'b1;
			cyc(4);
			i_osc_pin_one <= 1'b0;
			cyc(4);
		end
	endtask

	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	initial begin
		foreach (m_reg[i]) m_reg[i] = 0;
		repeat (2) @(posedge i_clk);
		i_arst_n <= 1'b1;
		#1;
		for (k = 0; k < 8; k++) rdm(k[2:0]);
		for (k = 0; k < 4; k++) begin
			wr(ETCU_OFS_COUNT, rnd());
			wr(ETCU_OFS_COMPARE, rnd());
			rdm(ETCU_OFS_COMPARE);
			rdm(ETCU_OFS_COUNT);
		end
		wr(3'h6, rnd());
		rdm(3'h6);
		// Count written equal to compare: first tick must not match
		wr(ETCU_OFS_COMPARE, 8'h10);
		wr(ETCU_OFS_COUNT, 8'h10);
		wr(ETCU_OFS_MASK, 8'hc0);
		rdm(ETCU_OFS_MASK);
		wr(ETCU_OFS_CONTROL, 8'h01);
		cyc(20);
		rdm(ETCU_OFS_FLAG);
		wait_irq(1'b1, 600);
		wait_irq(1'b0, 100);
		wr(ETCU_OFS_CONTROL, 8'h00);
		m_reg[4] = 8'hc0;
		rdm(ETCU_OFS_FLAG);
		wr(ETCU_OFS_FLAG, 8'h80);
		rdm(ETCU_OFS_FLAG);
		cyc(2);
		chk({7'h0, o_compare_irq}, 8'h00);
		ack(1'b1);
		m_reg[4] = 0;
		cyc(2);
		rdm(ETCU_OFS_FLAG);
		chk({7'h0, o_overflow_irq}, 8'h00);
		// Clear on match with toggle: top is the compare value
		wr(ETCU_OFS_COMPARE, 8'h05);
		wr(ETCU_OFS_COUNT, 8'h00);
		wr(ETCU_OFS_CONTROL, 8'h19);
		cyc(50);
		v = 8'h00;
		got = {7'h0, o_compare_output};
		for (k = 0; k < 12; k++) begin
			cyc(1);
			if (o_compare_output !== got[0]) v++;
			got = {7'h0, o_compare_output};
		end
		chk(v, 8'h02);
		chk({7'h0, o_compare_oe_n}, 8'h00);
		wr(ETCU_OFS_CONTROL, 8'h18);
		rd(ETCU_OFS_COUNT);
		chk({7'h0, got <= 8'h05}, 8'h01);
		m_reg[4] = 8'h80;
		rdm(ETCU_OFS_FLAG);
		ack(1'b0);
		m_reg[4] = 0;
		cyc(2);
		rdm(ETCU_OFS_FLAG);
		// Force toggles the output only; ignored once a PWM mode is set
		v = {7'h0, ~o_compare_output};
		wr(ETCU_OFS_CONTROL, 8'h98);
		cyc(2);
		chk({7'h0, o_compare_output}, v);
		rdm(ETCU_OFS_FLAG);
		wr(ETCU_OFS_CONTROL, 8'hd8);
		cyc(2);
		chk({7'h0, o_compare_output}, v);
		// Fast mode: buffered write leaves the old compare active
		wr(ETCU_OFS_COMPARE, 8'h80);
		wr(ETCU_OFS_COUNT, 8'h03);
		wr(ETCU_OFS_CONTROL, 8'h49);
		cyc(15);
		wr(ETCU_OFS_CONTROL, 8'h48);
		m_reg[4] = 8'h80;
		rdm(ETCU_OFS_FLAG);
		rdm(ETCU_OFS_COMPARE);
		// Masking the compare request drops it while the flag stays set
		wr(ETCU_OFS_MASK, 8'h40);
		rdm(ETCU_OFS_MASK);
		chk({7'h0, o_compare_irq}, 8'h00);
		wr(ETCU_OFS_FLAG, 8'hc0);
		// Phase mode turns at the maximum instead of wrapping
		wr(ETCU_OFS_COUNT, 8'hfa);
		wr(ETCU_OFS_CONTROL, 8'h41);
		cyc(30);
		wr(ETCU_OFS_CONTROL, 8'h40);
		rd(ETCU_OFS_COUNT);
		chk({7'h0, got >= 8'hd0 && got <= 8'hfa}, 8'h01);
		rdm(ETCU_OFS_FLAG);
		// Oscillator pin as tick source
		wr(ETCU_OFS_CONTROL, 8'h00);
		wr(ETCU_OFS_COUNT, 8'h00);
		wr(ETCU_OFS_ASYNC, 8'h08);
		rdm(ETCU_OFS_ASYNC);
		wr(ETCU_OFS_CONTROL, 8'h01);
		cyc(10);
		rdm(ETCU_OFS_COUNT);
		osc(1);
		m_reg[1] = 1;
		rdm(ETCU_OFS_COUNT);
		osc(4);
		m_reg[1] = 5;
		cyc(6);
		wr(ETCU_OFS_CONTROL, 8'h00);
		rdm(ETCU_OFS_COUNT);
		wr(ETCU_OFS_ASYNC, 8'h00);
		tally_and_finish();
	end
endmodule

bind etcu_timer etcu_timer_sva u_sva (
	.i_clk(i_clk), .i_arst_n(i_arst_n), .i_addr(i_addr),
	.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
	.i_osc_pin_one(i_osc_pin_one), .i_compare_ack(i_compare_ack),
	.i_overflow_ack(i_overflow_ack), .o_compare_irq(o_compare_irq),
	.o_overflow_irq(o_overflow_irq),
	.o_compare_output(o_compare_output),
	.o_compare_oe_n(o_compare_oe_n)
);
